/* File: pkg/bslw_pkg.sv */
// Constants for the BCD subtract and word logic unit.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package bslw_pkg;

  // Bus shape
  localparam int          ADR_W        = 8;
  localparam int          DAT_W        = 32;
  localparam int          WORD_W       = 16;
  localparam int          DIGITS       = 4;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_OPA      = 8'h04;
  localparam logic [7:0]  OFS_OPB      = 8'h08;
  localparam logic [7:0]  OFS_SUB_RES  = 8'h0c;
  localparam logic [7:0]  OFS_AND_RES  = 8'h10;
  localparam logic [7:0]  OFS_OR_RES   = 8'h14;
  localparam logic [7:0]  OFS_FLAGS    = 8'h18;
  localparam logic [7:0]  OFS_PTR      = 8'h1c;

  // Control field positions
  localparam int          CTL_SUB_EN   = 0;
  localparam int          CTL_SUB_DIFF = 1;
  localparam int          CTL_AND_EN   = 2;
  localparam int          CTL_OR_EN    = 3;
  localparam int          CTL_CLC_EN   = 4;
  localparam int          CTL_IND_EN   = 5;
  localparam int          CTL_W        = 6;

  // Flag field positions
  localparam int          FLG_CARRY    = 0;
  localparam int          FLG_FAULT    = 1;
  localparam int          FLG_ZERO     = 2;

  // Reset values
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  // Highest legal retention-area word index, in BCD
  localparam logic [15:0] RET_LAST     = 16'h0099;

  // Ten's complement bias of the four-digit subtraction
  localparam int          BCD_BIAS     = 10000;

endpackage

/* File: src/bslw_digit_sub.sv */
// One BCD digit stage of the ripple subtractor.
// Assumes both digits are valid BCD; the caller screens them.
`timescale 1ns/1ns
module bslw_digit_sub (
  // Digits in
  input  wire logic [3:0] a_in,       // Digit of first operand
  input  wire logic [3:0] b_in,       // Digit of second operand
  input  wire logic       borrow_in,  // Borrow from lower digit
  // Digit out
  output logic      [3:0] diff_out,   // Difference digit
  output logic            borrow_out  // Borrow to higher digit
);

  logic [4:0] raw;                    // Five-bit signed trial difference

  // Subtract, then fold a negative digit back by adding ten
  always_comb begin
    raw = {1'b0, a_in} - {1'b0, b_in} - {4'h0, borrow_in};
    if (raw[4]) begin
      diff_out   = raw[3:0] + 4'ha;
      borrow_out = 1'b1;
    end else begin
      diff_out   = raw[3:0];
      borrow_out = 1'b0;
    end
  end

endmodule

/* File: src/bslw_unit.sv */
// BCD subtract, word AND and word OR unit behind a Wishbone slave.
// Assumes one clock edge is one program scan and a classic bus master.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
// Functional notes
// - Subtract idle: result and zero flag untouched
// - Subtract operand B and carry from A
// - Negative difference sets carry, ten's complement
// - Compute 10000 plus A minus B minus carry
// - Non-BCD operand raises fault flag
// - Bad indirect pointer raises fault flag
// - Zero flag follows stored difference
// - Differentiated subtract runs once per rise
// - OR idle leaves its result unchanged
// - OR writes bitwise OR of inputs
// - Operands are four-digit BCD words
// - Carry clear forces carry flag off unless a subtract runs
module bslw_unit
  import bslw_pkg::*;
(
  // Clock and reset
  input  wire logic                        CLOCK_IN,
  input  wire logic                        RESETN_IN,
  // Wishbone slave
  input  wire logic                        WB_CYC_IN,
  input  wire logic                        WB_STB_IN,
  input  wire logic                        WB_WE_IN,
  input  wire logic [bslw_pkg::ADR_W-1:0]  WB_ADR_IN,
  input  wire logic [3:0]                  WB_SEL_IN,
  input  wire logic [bslw_pkg::DAT_W-1:0]  WB_DAT_IN,
  output logic      [bslw_pkg::DAT_W-1:0]  WB_DAT_OUT,
  output logic                             WB_ACK_OUT,
  // Flag outputs
  output logic                             CARRY_FLAG_OUT,
  output logic                             FAULT_FLAG_OUT,
  output logic                             ZERO_FLAG_OUT
);
  import bslw_pkg::*;

  // Checks that every nibble of a word is a decimal digit
  function automatic logic is_bcd(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (w[i*4 +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction

  // Decimal value of a BCD word, for checking only
  function automatic int bcd_val(input logic [15:0] w);
    int v;
    v = 0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      v = v * 10 + int'(w[i*4 +: 4]);
    end
    return v;
  endfunction

  // Register state
  logic [CTL_W-1:0]  ctrl_q;             // Execution conditions
  logic [15:0]       opa_q;              // First/left operand word
  logic [15:0]       opb_q;              // Second/right operand word
  logic [15:0]       ptr_q;              // Indirect pointer word
  logic [15:0]       sub_res_q;          // Difference output cell
  logic [15:0]       and_res_q;          // Conjunction output cell
  logic [15:0]       or_res_q;           // Disjunction output cell
  logic              carry_q;            // Carry flag
  logic              fault_q;            // Fault flag
  logic              zero_q;             // Zero flag
  logic              sub_prev_q;         // Subtract condition last scan
  logic              ack_q;              // Bus acknowledge
  logic [31:0]       rdat_q;             // Bus read data

  // Bus decode
  logic              bus_req;            // New access this cycle
  logic              wr_go;              // Write commits this cycle
  logic              wr_lo;              // Low byte lane written
  logic              wr_hi;              // High byte lane written
  logic [31:0]       rdat_d;             // Read mux

  // Datapath
  logic              sub_go;             // Subtract executes this scan
  logic              ind_bad;            // Indirect pointer unusable
  logic              sub_bad;            // Subtract refused for fault
  logic              cy_in;              // Carry seen by subtract
  logic [DIGITS:0]   brw;                // Digit borrow chain
  logic [15:0]       diff;               // Four-digit difference

  // One request per handshake; ack falls in the cycle after it rose
  assign bus_req = WB_CYC_IN & WB_STB_IN & ~ack_q;
  assign wr_go   = bus_req & WB_WE_IN;
  assign wr_lo   = wr_go & WB_SEL_IN[0];
  assign wr_hi   = wr_go & WB_SEL_IN[1];

  // Edge detect only in differentiated mode
  assign sub_go  = ctrl_q[CTL_SUB_EN] &
                   (~ctrl_q[CTL_SUB_DIFF] | ~sub_prev_q);
  // Pointer must be BCD and inside the area
  assign ind_bad = ctrl_q[CTL_IND_EN] &
                   (~is_bcd(ptr_q) | (ptr_q > RET_LAST));
  // Both operands screened as BCD words
  assign sub_bad = ind_bad | ~is_bcd(opa_q) | ~is_bcd(opb_q);
  // Carry clear in the same scan acts first
  assign cy_in   = ctrl_q[CTL_CLC_EN] ? 1'b0 : carry_q;

  // Ripple of four digit stages: 10000 + A - B - carry
  assign brw[0] = cy_in;
  for (genvar g = 0; g < DIGITS; g++) begin : g_dig
    bslw_digit_sub u_dig (
      .a_in       (opa_q[g*4 +: 4]),
      .b_in       (opb_q[g*4 +: 4]),
      .borrow_in  (brw[g]),
      .diff_out   (diff[g*4 +: 4]),
      .borrow_out (brw[g+1])
    );
  end

  // Bus handshake: answer one cycle after the request appears
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= bus_req ? rdat_d : 32'h0000_0000;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (WB_ADR_IN)
      OFS_CTRL:    rdat_d[CTL_W-1:0] = ctrl_q;
      OFS_OPA:     rdat_d[15:0]      = opa_q;
      OFS_OPB:     rdat_d[15:0]      = opb_q;
      OFS_SUB_RES: rdat_d[15:0]      = sub_res_q;
      OFS_AND_RES: rdat_d[15:0]      = and_res_q;
      OFS_OR_RES:  rdat_d[15:0]      = or_res_q;
      OFS_FLAGS: begin
        rdat_d[FLG_CARRY] = carry_q;
        rdat_d[FLG_FAULT] = fault_q;
        rdat_d[FLG_ZERO]  = zero_q;
      end
      OFS_PTR:     rdat_d[15:0]      = ptr_q;
      default:     rdat_d            = 32'h0000_0000;
    endcase
  end

  // Software-written control and operand words
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_q <= CTRL_RST;
      opa_q  <= WORD_RST;
      opb_q  <= WORD_RST;
      ptr_q  <= WORD_RST;
    end else begin
      if (wr_lo && WB_ADR_IN == OFS_CTRL) ctrl_q <= WB_DAT_IN[CTL_W-1:0];
      if (WB_ADR_IN == OFS_OPA) begin
        if (wr_lo) opa_q[7:0]  <= WB_DAT_IN[7:0];
        if (wr_hi) opa_q[15:8] <= WB_DAT_IN[15:8];
      end
      if (WB_ADR_IN == OFS_OPB) begin
        if (wr_lo) opb_q[7:0]  <= WB_DAT_IN[7:0];
        if (wr_hi) opb_q[15:8] <= WB_DAT_IN[15:8];
      end
      if (WB_ADR_IN == OFS_PTR) begin
        if (wr_lo) ptr_q[7:0]  <= WB_DAT_IN[7:0];
        if (wr_hi) ptr_q[15:8] <= WB_DAT_IN[15:8];
      end
    end
  end

  // Previous-scan copy of the subtract condition
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= ctrl_q[CTL_SUB_EN];
    end
  end

  // Difference cell and zero flag move only when subtract runs
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sub_res_q <= WORD_RST;
      zero_q    <= 1'b0;
    end else if (sub_go && !sub_bad) begin
      sub_res_q <= diff;
      zero_q    <= (diff == WORD_RST);
    end
  end

  // Carry: hardware outcome wins over a software write in the same cycle.
  // Software may write carry so the program can clear it itself.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      carry_q <= 1'b0;
    end else if (sub_go && !sub_bad) begin
      carry_q <= brw[DIGITS];
    end else if (ctrl_q[CTL_CLC_EN]) begin
      carry_q <= 1'b0;
    end else if (wr_lo && WB_ADR_IN == OFS_FLAGS) begin
      carry_q <= WB_DAT_IN[FLG_CARRY];
    end
  end

  // Fault reflects the last executed operation; a refused one sets it
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fault_q <= 1'b0;
    end else if (sub_go) begin
      fault_q <= sub_bad;
    end else if (ctrl_q[CTL_AND_EN] || ctrl_q[CTL_OR_EN]) begin
      fault_q <= ind_bad;
    end else if (wr_lo && WB_ADR_IN == OFS_FLAGS) begin
      fault_q <= WB_DAT_IN[FLG_FAULT];
    end
  end

  // Word conjunction; idle keeps the cell
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      and_res_q <= WORD_RST;
    end else if (ctrl_q[CTL_AND_EN] && !ind_bad) begin
      and_res_q <= opa_q & opb_q;
    end
  end

  // Word disjunction; idle keeps the cell
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      or_res_q <= WORD_RST;
    end else if (ctrl_q[CTL_OR_EN] && !ind_bad) begin
      or_res_q <= opa_q | opb_q;
    end
  end

  // Output ports straight from flip-flops
  assign WB_ACK_OUT     = ack_q;
  assign WB_DAT_OUT     = rdat_q;
  assign CARRY_FLAG_OUT = carry_q;
  assign FAULT_FLAG_OUT = fault_q;
  assign ZERO_FLAG_OUT  = zero_q;

  // Reference decimal outcome of the subtraction, for checking only
  int ref_val;
  assign ref_val = (BCD_BIAS + bcd_val(opa_q) - bcd_val(opb_q)
                    - int'(cy_in)) % BCD_BIAS;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_sub_idle_hold: assert property (
    !sub_go |=> $stable(sub_res_q) && $stable(zero_q))
    else $error("difference changed while idle");
  a_sub_value: assert property (
    sub_go && !sub_bad |=> bcd_val(sub_res_q) == $past(ref_val))
    else $error("difference value wrong");
  a_sub_neg_carry: assert property (
    sub_go && !sub_bad |=>
      carry_q == ($past(bcd_val(opa_q)) <
                  $past(bcd_val(opb_q)) + int'($past(cy_in))))
    else $error("carry does not match sign");
  a_fault_operand: assert property (
    sub_go && (!is_bcd(opa_q) || !is_bcd(opb_q)) |=>
      fault_q && $stable(sub_res_q))
    else $error("non-BCD operand not faulted");
  a_fault_pointer: assert property (
    ctrl_q[CTL_IND_EN] && ptr_q > RET_LAST && sub_go |=> fault_q)
    else $error("bad pointer not faulted");
  a_zero_track: assert property (
    sub_go && !sub_bad |=> zero_q == (sub_res_q == WORD_RST))
    else $error("zero flag wrong");
  a_diff_once: assert property (
    ctrl_q[CTL_SUB_DIFF] && $past(ctrl_q[CTL_SUB_EN]) |-> !sub_go)
    else $error("differentiated subtract repeated");
  a_or_hold: assert property (
    !ctrl_q[CTL_OR_EN] |=> $stable(or_res_q))
    else $error("OR cell changed while idle");
  a_or_value: assert property (
    ctrl_q[CTL_OR_EN] && !ind_bad |=>
      or_res_q == ($past(opa_q) | $past(opb_q)))
    else $error("OR result wrong");
  a_and_value: assert property (
    ctrl_q[CTL_AND_EN] && !ind_bad |=>
      and_res_q == ($past(opa_q) & $past(opb_q)))
    else $error("AND result wrong");
  a_clc_clear: assert property (
    ctrl_q[CTL_CLC_EN] && !sub_go |=> !carry_q)
    else $error("carry not cleared");
  a_ack_pulse: assert property (
    ack_q |=> !ack_q)
    else $error("ack held two cycles");

  c_sub_negative: cover property (sub_go && !sub_bad && brw[DIGITS]);
  c_sub_zero: cover property (sub_go && !sub_bad && diff == WORD_RST);
  c_sub_fault: cover property (sub_go && sub_bad);
  c_and_or: cover property (ctrl_q[CTL_AND_EN] && ctrl_q[CTL_OR_EN]);

endmodule

/* File: verification/bslw_tb.sv */
// Self-checking bench for the BCD subtract and word logic unit.
// Assumes the unit answers each bus request one cycle after it appears.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  failures++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end end
module tb;
  import bslw_pkg::*;
  // Clock, reset and bus drive
  logic              clk   = 1'b0;  // Scan clock
  logic              rst_n = 1'b0;  // Reset, active low
  logic              cyc   = 1'b0;  // Bus cycle
  logic              stb   = 1'b0;  // Bus strobe
  logic              we    = 1'b0;  // Write enable
  logic [ADR_W-1:0]  adr   = '0;    // Byte address
  logic [3:0]        sel   = '0;    // Byte lane enables
  logic [DAT_W-1:0]  wdat  = '0;    // Write data
  // Observed outputs
  logic [DAT_W-1:0]  rdat;          // Read data
  logic              ack;           // Acknowledge
  logic              carry;         // Carry pin
  logic              fault;         // Fault pin
  logic              zero;          // Zero pin
  // Bookkeeping
  logic [31:0]       seed = 32'h1733; // Random state
  // Note: [35] pins checked, [34:32] zero/fault/carry pins, [31:0] data
  logic [35:0]       exp_q[$];      // Expected results, oldest first
  logic [35:0]       mon_exp;       // Note taken by the monitor
  logic [15:0]       last;          // Last subtract result
  int                failures    = 0;
  int                comparisons = 0;
  int                ia, ib, v, n;
  logic              c;

  // Free-running clock
  always #5 clk = ~clk;

  bslw_unit bslw_unit_i (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CARRY_FLAG_OUT(carry),
    .FAULT_FLAG_OUT(fault), .ZERO_FLAG_OUT(zero)
  );

  // Galois-free shift register step for stimulus
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Decimal to four BCD digits
  function automatic logic [15:0] bcd(input int x);
    return {4'(x / 1000 % 10), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
  endfunction

  // Verdict and end of run
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic cycle; upper lanes carry junk since the unit ignores them
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {seed[31:16], d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!ack && k < 20);
    if (!ack) begin
      failures++;
      $display("wrong value bus ack expected 1 seen 0");
      complete_run();
    end else begin
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  // Note the expectation, then read
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({4'h0, 16'h0, e});
    bus(1'b0, a, 16'h0, 4'hf);
  endtask

  // Flags through the register and on the pins; order zero, fault, carry
  task automatic flags(input logic [2:0] e);
    exp_q.push_back({1'b1, e, 29'h0, e});
    bus(1'b0, OFS_FLAGS, 16'h0, 4'hf);
  endtask

  // Load carry and operands with the unit idle, then enable
  task automatic sub(input logic [15:0] a, b, input logic ci,
                     input logic [5:0] ctl);
    wr(OFS_CTRL, 16'h0);
    wr(OFS_FLAGS, {15'h0, ci});
    wr(OFS_OPA, a);
    wr(OFS_OPB, b);
    wr(OFS_CTRL, {10'h0, ctl});
  endtask

  // Read monitor: old ack and we at the edge mark a finished read
  always @(posedge clk) begin
    if (ack && !we) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value read data expected none seen %h", rdat);
      end else begin
        mon_exp = exp_q.pop_front();
        `CHK("read data", mon_exp[31:0], rdat)
        // Pins must agree with the register in the same cycle
        if (mon_exp[35]) begin
          `CHK("flag pins", mon_exp[34:32], {zero, fault, carry})
        end
      end
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    flags(3'b000);
    rd(OFS_SUB_RES, 16'h0000);
    // Negative difference, run once on the rise only
    sub(16'h0089, 16'h0100, 1'b0, 6'h03);
    rd(OFS_SUB_RES, 16'h9989);
    flags(3'b001);
    repeat (3) @(posedge clk);
    rd(OFS_SUB_RES, 16'h9989);
    // Recover the true value: carry cleared in the same scan first
    sub(16'h0000, 16'h9989, 1'b1, 6'h13);
    rd(OFS_SUB_RES, 16'h0011);
    flags(3'b000);
    sub(16'h0100, 16'h0100, 1'b0, 6'h03);
    rd(OFS_SUB_RES, 16'h0000);
    flags(3'b100);
    // Non-BCD operands: result, carry and zero held, fault raised
    sub(16'h00a0, 16'h0001, 1'b1, 6'h03);
    flags(3'b111);
    sub(16'h0001, 16'h0f00, 1'b1, 6'h03);
    flags(3'b111);
    rd(OFS_SUB_RES, 16'h0000);
    // Pointer beyond the area, non-BCD pointer, then the last legal one
    wr(OFS_PTR, 16'h0100);
    sub(16'h0005, 16'h0003, 1'b0, 6'h23);
    flags(3'b110);
    wr(OFS_PTR, 16'h00a5);
    sub(16'h0005, 16'h0003, 1'b0, 6'h23);
    flags(3'b110);
    wr(OFS_PTR, RET_LAST);
    sub(16'h0005, 16'h0003, 1'b0, 6'h23);
    rd(OFS_SUB_RES, 16'h0002);
    flags(3'b000);
    // Random operands and carry, all three operations enabled
    for (n = 0; n < 8; n++) begin
      seed = nxt(seed);
      ia = int'(seed % 10000);
      seed = nxt(seed);
      ib = int'(seed % 10000);
      c = seed[7];
      sub(bcd(ia), bcd(ib), c, 6'h0f);
      v = BCD_BIAS + ia - ib - int'(c);
      last = bcd(v % 10000);
      rd(OFS_SUB_RES, last);
      rd(OFS_AND_RES, bcd(ia) & bcd(ib));
      rd(OFS_OR_RES, bcd(ia) | bcd(ib));
      flags({v % 10000 == 0, 1'b0, v < BCD_BIAS});
    end
    // Full-width words in differentiated mode
    wr(OFS_OPA, 16'hf0a5);
    wr(OFS_OPB, 16'h3c3c);
    rd(OFS_AND_RES, 16'h3024);
    rd(OFS_OR_RES, 16'hfcbd);
    // Idle unit keeps its cells; result cells ignore writes
    wr(OFS_CTRL, 16'h0);
    wr(OFS_OPA, 16'hffff);
    wr(OFS_SUB_RES, 16'h1234);
    rd(OFS_AND_RES, 16'h3024);
    rd(OFS_OR_RES, 16'hfcbd);
    rd(OFS_SUB_RES, last);
    flags({v % 10000 == 0, 1'b0, v < BCD_BIAS});
    // Low lane only: high byte of the operand word is kept
    bus(1'b1, OFS_OPB, 16'hffff, 4'h1);
    rd(OFS_OPB, 16'h3cff);
    rd(8'h20, 16'h0000);
    // Let the monitor take the last note, bounded
    for (n = 0; n < 10 && exp_q.size() != 0; n++) begin
      @(posedge clk);
    end
    if (exp_q.size() != 0) begin
      failures++;
    end
    complete_run();
  end
endmodule
